// ### verilog/vcds_top.sv
// Volume ramp and clock detect status registers of the processing core
module vcds_top (
  input  wire logic                      CLK_I,
  input  wire logic                      RST_N_I,
  input  wire logic [vcds_pkg::ADDR_W-1:0] REG_ADDR_I,
  input  wire logic                      REG_WR_I,
  input  wire logic [vcds_pkg::DATA_W-1:0] REG_WDATA_I,
  input  wire logic                      REG_RD_I,
  output logic      [vcds_pkg::DATA_W-1:0] REG_RDATA_O,
  output logic                           REG_RVALID_O,
  input  wire logic [vcds_pkg::VOL_W-1:0]  L_VOL_I,
  input  wire logic [vcds_pkg::VOL_W-1:0]  L_TARGET_I,
  input  wire logic [vcds_pkg::VOL_W-1:0]  R_VOL_I,
  input  wire logic [vcds_pkg::VOL_W-1:0]  R_TARGET_I,
  input  wire logic [vcds_pkg::PER_W-1:0]  FRAME_PERIOD_I,
  input  wire logic [vcds_pkg::MRAT_W-1:0] MCLK_RATIO_I,
  input  wire logic                      PLL_DISABLED_I,
  input  wire logic [vcds_pkg::BRAT_W-1:0] BIT_CLOCK_RATIO_I,
  output logic                           CLOCK_ERROR_O
);
  import vcds_pkg::*;

  // ****************************************
  // Monitor wiring
  // ****************************************
  vcds_vol_if vol_bus ();
  vcds_clk_if clk_bus ();

  // Detector inputs share the core clock, so no synchroniser
  assign vol_bus.cur[CH_LEFT]  = L_VOL_I;
  assign vol_bus.tgt[CH_LEFT]  = L_TARGET_I;
  assign vol_bus.cur[CH_RIGHT] = R_VOL_I;
  assign vol_bus.tgt[CH_RIGHT] = R_TARGET_I;
  assign clk_bus.per           = FRAME_PERIOD_I;
  assign clk_bus.ratio         = MCLK_RATIO_I;
  assign clk_bus.pll_off       = PLL_DISABLED_I;

  vcds_vol_mon u_vol (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .vol     (vol_bus)
  );

  vcds_clk_class u_clk (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .clk     (clk_bus)
  );

  // ****************************************
  // Bit clock ratio capture
  // ****************************************
  logic [BRAT_W-1:0] brat_d;
  logic [BRAT_W-1:0] brat_q;

  // Follows the detector every cycle, zero out of reset
  always_comb
  begin
    brat_d = BIT_CLOCK_RATIO_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      brat_q <= '0;
    else
      brat_q <= brat_d;
  end

  // ****************************************
  // Address decode
  // ****************************************
  // Returns hit flag above the register index
  function automatic logic [2:0] reg_decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [2:0] res;
    res = {1'b0, IDX_VOL};
    case (addr)
      ADDR_VOL:  res = {1'b1, IDX_VOL};
      ADDR_RATE: res = {1'b1, IDX_RATE};
      ADDR_BHI:  res = {1'b1, IDX_BHI};
      ADDR_BLO:  res = {1'b1, IDX_BLO};
      default:   res = {1'b0, IDX_VOL};
    endcase
    return res;
  endfunction : reg_decode

  logic [2:0] wr_dec;
  logic [2:0] rd_dec;
  logic       wr_hit;
  logic       rd_hit;
  vcds_idx_t  wr_idx;
  vcds_idx_t  rd_idx;

  // Same decode serves both directions
  always_comb
  begin
    wr_dec = reg_decode(REG_ADDR_I);
    rd_dec = reg_decode(REG_ADDR_I);
    wr_hit = REG_WR_I && wr_dec[2];
    rd_hit = REG_RD_I && rd_dec[2];
    wr_idx = wr_dec[1:0];
    rd_idx = rd_dec[1:0];
  end

  // ****************************************
  // Reserved storage
  // ****************************************
  logic [DATA_W-1:0] rsv_d [NUM_REG];
  logic [DATA_W-1:0] rsv_q [NUM_REG];

  // Only reserved bits take a write; read-only bits drop it
  always_comb
  begin
    for (int r = 0; r < NUM_REG; r++)
      rsv_d[r] = rsv_q[r];
    if (wr_hit)
      rsv_d[wr_idx] = REG_WDATA_I & RSV_MASK[wr_idx];
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      for (int r = 0; r < NUM_REG; r++)
        rsv_q[r] <= REG_RESET;
    end
    else
    begin
      for (int r = 0; r < NUM_REG; r++)
        rsv_q[r] <= rsv_d[r];
    end
  end

  // ****************************************
  // Status words
  // ****************************************
  logic [DATA_W-1:0] stat_w [NUM_REG];

  // Hardware fields are placed over a zero background
  always_comb
  begin
    for (int r = 0; r < NUM_REG; r++)
      stat_w[r] = '0;
    stat_w[IDX_VOL][BIT_L_RAMP] = vol_bus.ramp[CH_LEFT];
    stat_w[IDX_VOL][BIT_L_DONE] = vol_bus.done[CH_LEFT];
    stat_w[IDX_VOL][BIT_R_RAMP] = vol_bus.ramp[CH_RIGHT];
    stat_w[IDX_VOL][BIT_R_DONE] = vol_bus.done[CH_RIGHT];
    stat_w[IDX_RATE][RATE_LSB +: 3] = clk_bus.rate;
    stat_w[IDX_RATE][MRAT_LSB +: 4] = clk_bus.code;
    stat_w[IDX_BHI][BHI_LSB +: 2] = brat_q[BRAT_W-1:1];
    stat_w[IDX_BLO][BLO_BIT]      = brat_q[0];
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_d;
  logic              rvalid_q;

  // Unmapped reads answer zero; data holds until the next read
  always_comb
  begin
    rdata_d  = rdata_q;
    rvalid_d = REG_RD_I;
    if (REG_RD_I)
    begin
      if (rd_hit)
        rdata_d = (rsv_q[rd_idx] & RSV_MASK[rd_idx]) | stat_w[rd_idx];
      else
        rdata_d = '0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign REG_RDATA_O   = rdata_q;
  assign REG_RVALID_O  = rvalid_q;
  assign CLOCK_ERROR_O = clk_bus.err;

  // ****************************************
  // Checks
  // ****************************************
  // Ramp and done flags track the previous cycle's inputs
  l_ramp_flag_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (L_VOL_I != L_TARGET_I) |=> vol_bus.ramp[CH_LEFT] &&
                                 !vol_bus.done[CH_LEFT])
    else $error("left ramp flag wrong");

  l_done_flag_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (L_VOL_I == L_TARGET_I) |=> vol_bus.done[CH_LEFT] &&
                                 !vol_bus.ramp[CH_LEFT])
    else $error("left done flag wrong");

  r_ramp_flag_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    $changed(R_VOL_I) && (R_VOL_I != R_TARGET_I) |=>
      vol_bus.ramp[CH_RIGHT])
    else $error("right ramp flag missed a step");

  r_done_flag_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (R_VOL_I != R_TARGET_I) ##1 (R_VOL_I == R_TARGET_I) |=>
      vol_bus.done[CH_RIGHT] && $past(!vol_bus.done[CH_RIGHT]))
    else $error("right done flag late");

  // Read of the rate register returns the live fields
  rate_read_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    REG_RD_I && (REG_ADDR_I == ADDR_RATE) |=>
      REG_RVALID_O &&
      (REG_RDATA_O[RATE_LSB +: 3] == $past(clk_bus.rate)) &&
      (REG_RDATA_O[MRAT_LSB +: 4] == $past(clk_bus.code)))
    else $error("rate register read mismatch");

  rate_mid_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (FRAME_PERIOD_I == 16'h1458) |=> (clk_bus.rate == 3'h3))
    else $error("48 kHz frame not coded 011");

  rate_zero_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (FRAME_PERIOD_I == 16'h0000) |=>
      (clk_bus.rate == RATE_ERR) && CLOCK_ERROR_O)
    else $error("zero period not an error");

  ratio_bad_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (MCLK_RATIO_I == 12'h064) |=>
      (clk_bus.code == MRAT_ERR) && CLOCK_ERROR_O)
    else $error("illegal ratio not coded 0000");

  ratio_ends_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    ((MCLK_RATIO_I == 12'h020) |=> (clk_bus.code == 4'h1)) and
    ((MCLK_RATIO_I == 12'hc00) |=> (clk_bus.code == 4'he)))
    else $error("ratio end codes wrong");

  nopll_slow_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    PLL_DISABLED_I && (MCLK_RATIO_I == 12'h040) |=> CLOCK_ERROR_O)
    else $error("low ratio without pll not flagged");

  fast_mclk_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (MCLK_RATIO_I == 12'h400) && (FRAME_PERIOD_I == 16'h0a2c) |=>
      CLOCK_ERROR_O && (clk_bus.code != MRAT_ERR))
    else $error("master clock above limit not flagged");

  brat_read_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    REG_RD_I && (REG_ADDR_I == ADDR_BHI) ##1
    REG_RD_I && (REG_ADDR_I == ADDR_BLO) |=>
      ({$past(REG_RDATA_O[BHI_LSB +: 2]), REG_RDATA_O[BLO_BIT]} ==
       $past(brat_q, 2)) || ($past(brat_q) != $past(brat_q, 2)))
    else $error("bit clock ratio read mismatch");

  rsv_store_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    REG_WR_I && (REG_ADDR_I == ADDR_VOL) ##1
    REG_RD_I && (REG_ADDR_I == ADDR_VOL) && !REG_WR_I |=>
      (REG_RDATA_O & RSV_MASK[IDX_VOL]) ==
      ($past(REG_WDATA_I, 2) & RSV_MASK[IDX_VOL]))
    else $error("reserved bits not stored");

  unmapped_zero_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    REG_RD_I && !rd_hit |=> REG_RVALID_O && (REG_RDATA_O == '0))
    else $error("unmapped read not zero");
endmodule : vcds_top

// ### verilog/vcds_pkg.sv
// Constants and types for the volume and clock detect status bank
package vcds_pkg;
  // ****************************************
  // Widths and register map
  // ****************************************
  localparam int         NUM_CH     = 2;
  localparam int         CH_LEFT    = 0;
  localparam int         CH_RIGHT   = 1;
  localparam int         VOL_W      = 8;
  localparam int         PER_W      = 16;
  localparam int         MRAT_W     = 12;
  localparam int         BRAT_W     = 3;
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 8;
  localparam int         NUM_REG    = 4;
  typedef logic [1:0]    vcds_idx_t;
  typedef logic [2:0]    vcds_rate_t;
  typedef logic [3:0]    vcds_mrat_t;
  localparam logic [7:0] ADDR_VOL   = 8'h59;
  localparam logic [7:0] ADDR_RATE  = 8'h5b;
  localparam logic [7:0] ADDR_BHI   = 8'h5c;
  localparam logic [7:0] ADDR_BLO   = 8'h5d;
  localparam vcds_idx_t  IDX_VOL    = 2'h0;
  localparam vcds_idx_t  IDX_RATE   = 2'h1;
  localparam vcds_idx_t  IDX_BHI    = 2'h2;
  localparam vcds_idx_t  IDX_BLO    = 2'h3;
  // Field positions
  localparam int         BIT_L_RAMP = 5;
  localparam int         BIT_L_DONE = 4;
  localparam int         BIT_R_RAMP = 1;
  localparam int         BIT_R_DONE = 0;
  localparam int         RATE_LSB   = 4;
  localparam int         MRAT_LSB   = 0;
  localparam int         BHI_LSB    = 0;
  localparam int         BLO_BIT    = 7;
  // Writable reserved bits per register index, and reset value
  localparam logic [7:0] RSV_MASK [NUM_REG] = '{8'hcc, 8'h80, 8'hfc, 8'h7f};
  localparam logic [7:0] REG_RESET  = 8'h00;
  // ****************************************
  // Detection codes and clock figures
  // ****************************************
  localparam vcds_rate_t RATE_ERR   = 3'h0;
  localparam vcds_mrat_t MRAT_ERR   = 4'h0;
  localparam int         NUM_RATE   = 6;
  localparam int         NUM_MRAT   = 14;
  localparam int         CLK_KHZ    = 250000;
  localparam int         CLK_MHZ    = CLK_KHZ / 1000;
  localparam int         MCLK_MAX_MHZ = 50;
  localparam int         TOL_PCT    = 2;
  localparam int         MIN_RATIO_NOPLL = 128;
  // Rate window edges in units of 100 Hz, by rate code
  localparam int RATE_LO [1:6] = '{80, 160, 320, 882, 1764, 3840};
  localparam int RATE_HI [1:6] = '{80, 160, 480, 960, 1920, 3840};
  // Master clock ratios in FS, by ratio code
  localparam int MRAT_TAB [1:14] = '{32, 48, 64, 128, 192, 256, 384, 512,
                                     768, 1024, 1152, 1536, 2048, 3072};
  // Shortest frame period in core cycles for the top rate of a window
  function automatic int per_min(input int hi_rate);
    return (CLK_KHZ * 1000) / (hi_rate * (100 + TOL_PCT));
  endfunction : per_min
  // Longest frame period in core cycles for the bottom rate of a window
  function automatic int per_max(input int lo_rate);
    return (CLK_KHZ * 1000) / (lo_rate * (100 - TOL_PCT));
  endfunction : per_max
endpackage : vcds_pkg

// ### verilog/vcds_if.sv
// Interfaces between the status bank top and its two monitors
interface vcds_vol_if;
  import vcds_pkg::*;
  logic [VOL_W-1:0]  cur  [NUM_CH];
  logic [VOL_W-1:0]  tgt  [NUM_CH];
  logic [NUM_CH-1:0] ramp;
  logic [NUM_CH-1:0] done;
  modport mon (input cur, input tgt, output ramp, output done);
  modport top (output cur, output tgt, input ramp, input done);
endinterface : vcds_vol_if

interface vcds_clk_if;
  import vcds_pkg::*;
  logic [PER_W-1:0]  per;
  logic [MRAT_W-1:0] ratio;
  logic              pll_off;
  vcds_rate_t        rate;
  vcds_mrat_t        code;
  logic              err;
  modport mon (input per, input ratio, input pll_off,
               output rate, output code, output err);
  modport top (output per, output ratio, output pll_off,
               input rate, input code, input err);
endinterface : vcds_clk_if

// ### verilog/vcds_vol_mon.sv
// Per-channel digital volume ramp monitor
module vcds_vol_mon (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  vcds_vol_if.mon   vol
);
  import vcds_pkg::*;
  logic [NUM_CH-1:0] ramp_d;
  logic [NUM_CH-1:0] ramp_q;
  logic [NUM_CH-1:0] done_d;
  logic [NUM_CH-1:0] done_q;

  // Moving while off target, reached once equal; never both at once
  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      ramp_d[ch] = (vol.cur[ch] != vol.tgt[ch]);
      done_d[ch] = (vol.cur[ch] == vol.tgt[ch]);
    end
  end

  // Registered so a read sees one stable snapshot
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ramp_q <= '0;
      done_q <= '0;
    end
    else
    begin
      ramp_q <= ramp_d;
      done_q <= done_d;
    end
  end

  assign vol.ramp = ramp_q;
  assign vol.done = done_q;
endmodule : vcds_vol_mon

// ### verilog/vcds_clk_class.sv
// Sample rate and master clock ratio classifier with clock error
module vcds_clk_class (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  vcds_clk_if.mon   clk
);
  import vcds_pkg::*;
  vcds_rate_t rate_d;
  vcds_rate_t rate_q;
  vcds_mrat_t code_d;
  vcds_mrat_t code_q;
  logic       err_d;
  logic       err_q;
  logic       too_fast;
  logic       too_slow;

  // Window match on frame period; exact match on ratio
  always_comb
  begin
    rate_d = RATE_ERR;
    code_d = MRAT_ERR;
    for (int i = 1; i <= NUM_RATE; i++)
    begin
      if (int'(clk.per) >= per_min(RATE_HI[i]) &&
          int'(clk.per) <= per_max(RATE_LO[i]))
        rate_d = vcds_rate_t'(i);
    end
    for (int i = 1; i <= NUM_MRAT; i++)
    begin
      if (int'(clk.ratio) == MRAT_TAB[i])
        code_d = vcds_mrat_t'(i);
    end
    // Master clock rate is ratio times core rate over frame period
    too_fast = (int'(clk.ratio) * CLK_MHZ) >=
               (int'(clk.per) * MCLK_MAX_MHZ);
    too_slow = clk.pll_off &&
               (int'(clk.ratio) < MIN_RATIO_NOPLL);
    err_d = (rate_d == RATE_ERR) || (code_d == MRAT_ERR) ||
            too_fast || too_slow;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rate_q <= RATE_ERR;
      code_q <= MRAT_ERR;
      err_q  <= 1'b0;
    end
    else
    begin
      rate_q <= rate_d;
      code_q <= code_d;
      err_q  <= err_d;
    end
  end

  assign clk.rate = rate_q;
  assign clk.code = code_q;
  assign clk.err  = err_q;
endmodule : vcds_clk_class

// ### verification/vcds_tb_top.sv
// Self-checking testbench for the volume and clock detect status bank
module vcds_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import vcds_pkg::*;

  // ****************************************
  // Signals, clock and watchdog
  // ****************************************
  localparam int WDOG_CYC = 20000;
  logic              clk;
  logic              rst_n;
  logic [7:0]        addr;
  logic              wr;
  logic [7:0]        wdata;
  logic              rd;
  logic [7:0]        rdata;
  logic              rvalid;
  logic [7:0]        l_vol;
  logic [7:0]        l_tgt;
  logic [7:0]        r_vol;
  logic [7:0]        r_tgt;
  logic [15:0]       period;
  logic [11:0]       ratio;
  logic              pll_off;
  logic [2:0]        bcr;
  logic              clk_err;
  int                mismatches;
  int                check_count;

  vcds_top uut (
    .CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .L_VOL_I(l_vol), .L_TARGET_I(l_tgt),
    .R_VOL_I(r_vol), .R_TARGET_I(r_tgt), .FRAME_PERIOD_I(period),
    .MCLK_RATIO_I(ratio), .PLL_DISABLED_I(pll_off),
    .BIT_CLOCK_RATIO_I(bcr), .CLOCK_ERROR_O(clk_err)
  );

  // 250 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cuts a hang short; a few hundred cycles are really needed
  initial
  begin
    #(WDOG_CYC * 4);
    mismatches++;
    end_sim();
  end

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  // Answer is registered by the taking edge itself and checked 1 ns after it
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd = 1'b0;
    chk1(rvalid, 1'b1);
    d = rdata;
  endtask : rd_reg

  // Back to back reads: the strobe stays up while the address moves on
  task automatic rd_pair(input logic [7:0] a0, input logic [7:0] a1,
                         output logic [7:0] d0, output logic [7:0] d1);
    @(posedge clk);
    #1 rd = 1'b1;
    addr = a0;
    @(posedge clk);
    #1 addr = a1;
    chk1(rvalid, 1'b1);
    d0 = rdata;
    @(posedge clk);
    #1 rd = 1'b0;
    chk1(rvalid, 1'b1);
    d1 = rdata;
  endtask : rd_pair

  // Write then read on the very next edge; the read sees the stored bits
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd,
                       output logic [7:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wdata = wd;
    @(posedge clk);
    #1 wr = 1'b0;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    chk1(rvalid, 1'b1);
    d = rdata;
  endtask : wr_rd

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask : wr_reg

  // Status flops need one edge to follow the inputs
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic set_clk(input int p, input int r, input logic off);
    period = 16'(p);
    ratio = 12'(r);
    pll_off = off;
    settle();
  endtask : set_clk

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic vol_case(input logic [7:0] lv, input logic [7:0] rv,
                          input logic [7:0] exp);
    logic [7:0] d;
    l_vol = lv;
    r_vol = rv;
    settle();
    rd_reg(ADDR_VOL, d);
    chk8(d, exp);
  endtask : vol_case

  task automatic test_vol();
    l_tgt = 8'h40;
    r_tgt = 8'h20;
    vol_case(8'h10, 8'h20, 8'h21);
    vol_case(8'h40, 8'h21, 8'h12);
    vol_case(8'h3f, 8'h1f, 8'h22);
    vol_case(8'h40, 8'h20, 8'h11);
  endtask : test_vol

  // One frame period inside each rate window, ratio code 6
  task automatic test_rate();
    logic [7:0] d;
    for (int c = 1; c <= NUM_RATE; c++)
    begin
      set_clk(CLK_KHZ * 10 / RATE_HI[c], 256, 1'b0);
      rd_reg(ADDR_RATE, d);
      chk8(d, {1'b0, 3'(c), 4'h6});
    end
    set_clk(4000, 256, 1'b0);
    rd_reg(ADDR_RATE, d);
    chk8(d, 8'h06);
    chk1(clk_err, 1'b1);
    // A stopped frame clock gives no period at all
    set_clk(0, 256, 1'b0);
    rd_reg(ADDR_RATE, d);
    chk8(d, 8'h06);
    chk1(clk_err, 1'b1);
  endtask : test_rate

  // At 8 kHz every table ratio stays well under the clock ceiling
  task automatic test_ratio();
    logic [7:0] d;
    for (int c = 1; c <= NUM_MRAT; c++)
    begin
      set_clk(31250, MRAT_TAB[c], 1'b0);
      rd_reg(ADDR_RATE, d);
      chk8(d, {4'h1, 4'(c)});
      chk1(clk_err, 1'b0);
    end
    set_clk(31250, 100, 1'b0);
    rd_reg(ADDR_RATE, d);
    chk8(d, 8'h10);
    chk1(clk_err, 1'b1);
  endtask : test_ratio

  task automatic test_err();
    logic [7:0] d;
    set_clk(5208, 1024, 1'b0);
    chk1(clk_err, 1'b0);
    set_clk(5208, 1152, 1'b0);
    rd_reg(ADDR_RATE, d);
    chk8(d, 8'h3b);
    chk1(clk_err, 1'b1);
    set_clk(2604, 1024, 1'b0);
    chk1(clk_err, 1'b1);
    set_clk(31250, 64, 1'b1);
    chk1(clk_err, 1'b1);
    set_clk(31250, 128, 1'b1);
    chk1(clk_err, 1'b0);
  endtask : test_err

  task automatic test_bcr();
    logic [7:0] d;
    logic [7:0] d2;
    for (int b = 0; b < 8; b++)
    begin
      bcr = 3'(b);
      settle();
      rd_reg(ADDR_BHI, d);
      chk8(d, {6'h00, bcr[2:1]});
      rd_reg(ADDR_BLO, d);
      chk8(d, {bcr[0], 7'h00});
      rd_pair(ADDR_BHI, ADDR_BLO, d, d2);
      chk8(d, {6'h00, bcr[2:1]});
      chk8(d2, {bcr[0], 7'h00});
    end
  endtask : test_bcr

  // Reserved bits store, status bits ignore writes, reset clears
  task automatic test_write();
    logic [7:0] a [4];
    logic [7:0] st [4];
    logic [7:0] d;
    a = '{ADDR_VOL, ADDR_RATE, ADDR_BHI, ADDR_BLO};
    st = '{8'h21, 8'h36, 8'h02, 8'h80};
    l_vol = 8'h10;
    r_vol = 8'h20;
    bcr = 3'h5;
    set_clk(5208, 256, 1'b0);
    for (int i = 0; i < NUM_REG; i++)
    begin
      wr_rd(a[i], 8'hff, d);
      chk8(d, st[i] | RSV_MASK[i]);
      wr_reg(a[i], 8'h00);
      rd_reg(a[i], d);
      chk8(d, st[i]);
      wr_reg(a[i], 8'hff);
    end
    wr_reg(8'h5a, 8'hff);
    rd_reg(8'h5a, d);
    chk8(d, 8'h00);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk1(clk_err, 1'b0);
    chk8(rdata, 8'h00);
    rst_n = 1'b1;
    settle();
    for (int i = 0; i < NUM_REG; i++)
    begin
      rd_reg(a[i], d);
      chk8(d, st[i]);
    end
  endtask : test_write

  task automatic end_sim();
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // Main sequence: reset held for five cycles, then every scenario
  initial
  begin
    mismatches = 0;
    check_count = 0;
    rst_n = 1'b0;
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
    l_vol = 8'h00;
    l_tgt = 8'h00;
    r_vol = 8'h00;
    r_tgt = 8'h00;
    period = 16'd5208;
    ratio = 12'd256;
    pll_off = 1'b0;
    bcr = 3'h0;
    repeat (5) @(posedge clk);
    #1 chk1(rvalid, 1'b0);
    chk1(clk_err, 1'b0);
    rst_n = 1'b1;
    test_vol();
    test_rate();
    test_ratio();
    test_err();
    test_bcr();
    test_write();
    end_sim();
  end
endmodule : vcds_tb_top
